// file: src/sesw_status.sv
// Purpose: Extended status word of the wind instrument, APB readable
// Assumes: Measurement, fault and heating inputs are pclk-synchronous
// Notes: Telegram strobe clears the restart flag
//
// Summary of operation
// [RL1] Averaging under 10 s: bit 0 set after 10 s without new value.
// [RL2] Averaging 10 s or more: bit 0 set when buffer under half expected.
// [RL3] Bit 1 follows the heating switch-on criterion.
// [RL4] Bit 2 follows the actual heating state.
// [RL5] Bit 4 set when a static fault lasts more than one minute.
// [RL6] Buffer fill level reported in bits 8 to 11.
// [RL7] Fill code n means above n/16 and at most (n+1)/16.
// [RL8] Restart flag bit 13 clears with first telegram after restart.
// [RL9] Restart flag set on every restart.
// [RL10] Bits 3, 5-7, 12, 14-31 read zero.
`timescale 1ns/10ps
module sesw_status
  import sesw_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = CYC_PER_S,
  parameter int unsigned BUF_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic new_value,
  input wire logic [BUF_W-1:0] buf_count,
  input wire logic heat_crit,
  input wire logic heat_on,
  input wire logic static_cond,
  input wire logic telegram_sent,
  output logic irq
);
  // ************************************************
  // Registers
  // ************************************************
  logic [15:0] ctrl_reg, ctrl_next;
  logic [BUF_W-1:0] cap_reg, cap_next;
  logic [2:0] evt_reg, evt_next;
  logic [2:0] mask_reg, mask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic rdy_reg, rdy_next;
  logic irq_reg, irq_next;
  sesw_stat_s st_reg, st_next;
  logic noval_exp;
  logic static_exp;
  logic [3:0] fill_code;
  logic gen_now;
  logic [BUF_W+1:0] need2;
  logic wr_acc;
  logic rd_acc;

  function automatic logic [31:0] pack_word(input sesw_stat_s s);
    logic [31:0] w;
    w = 32'h0;
    w[BIT_GEN] = s.gen_fault;
    w[BIT_HCRIT] = s.heat_crit;
    w[BIT_HON] = s.heat_on;
    w[BIT_STATIC] = s.static_fault;
    w[FILL_LSB +: 4] = s.fill;
    w[BIT_RESTART] = s.restart;
    return w; // RL10
  endfunction

  function automatic logic [BUF_W:0] count_ext(input logic [BUF_W-1:0] c);
    return {1'b0, c};
  endfunction

  // ************************************************
  // Fault timers
  // ************************************************
  sesw_sec_timer #(
    .CYC_PER_SEC(CYC_PER_SEC),
    .LIMIT_S(NOVAL_TIME_S),
    .STRICT(1'b0)
  ) u_noval (
    .pclk(pclk),
    .presetn(presetn),
    .clear(new_value),
    .expired(noval_exp)
  );
  sesw_sec_timer #(
    .CYC_PER_SEC(CYC_PER_SEC),
    .LIMIT_S(STATIC_TIME_S),
    .STRICT(1'b1)
  ) u_static (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!static_cond),
    .expired(static_exp)
  );

  // ************************************************
  // Status computation
  // ************************************************
  always_comb begin
    // Ceil(16*count/cap)-1, saturating; empty buffer reads code 0
    logic [BUF_W+4:0] scaled;
    logic [BUF_W+4:0] q;
    scaled = {count_ext(buf_count), 4'h0};
    q = '0;
    if (cap_reg != 0 && buf_count != 0) begin
      q = (scaled + {5'h0, cap_reg} - 1'b1) / {5'h0, cap_reg};
    end
    if (q > 16) begin
      fill_code = 4'hf;
    end else if (q == 0) begin
      fill_code = 4'h0;
    end else begin
      fill_code = 4'(q - 1); // RL7
    end
  end

  // Averaging time in seconds equals expected values at one per second
  assign need2 = {1'b0, buf_count, 1'b0};
  always_comb begin
    if (ctrl_reg < 16'(AVG_LONG_S)) begin
      gen_now = noval_exp; // RL1
    end else begin
      gen_now = (need2 < {{(BUF_W+2-16){1'b0}}, ctrl_reg}); // RL2
    end
  end

  assign wr_acc = psel && penable && pwrite && rdy_reg;
  assign rd_acc = psel && penable && !pwrite && rdy_reg;

  always_comb begin
    st_next = st_reg;
    st_next.gen_fault = gen_now;
    st_next.heat_crit = heat_crit; // RL3
    st_next.heat_on = heat_on; // RL4
    st_next.static_fault = static_exp; // RL5
    st_next.fill = fill_code; // RL6
    if (telegram_sent) begin
      st_next.restart = 1'b0; // RL8
    end
  end

  // ************************************************
  // APB slave and interrupts
  // ************************************************
  always_comb begin
    ctrl_next = ctrl_reg;
    cap_next = cap_reg;
    mask_next = mask_reg;
    evt_next = evt_reg;
    rdata_next = rdata_reg;
    err_next = 1'b0;
    rdy_next = 1'b0;
    if (psel && !penable) begin
      rdy_next = 1'b1;
    end
    if (psel && penable && rdy_reg) begin
      rdy_next = 1'b0;
    end
    if (psel && !penable) begin
      rdata_next = 32'h0;
      if (paddr == ADDR_STATUS) begin
        rdata_next = pack_word(st_reg);
      end else if (paddr == ADDR_CTRL) begin
        rdata_next = {16'h0, ctrl_reg};
      end else if (paddr == ADDR_BUFCNT) begin
        rdata_next = 32'(cap_reg);
      end else if (paddr == ADDR_EVENT) begin
        rdata_next = {29'h0, evt_reg};
      end else if (paddr == ADDR_MASK) begin
        rdata_next = {29'h0, mask_reg};
      end else if (paddr != ADDR_TELEGRAM) begin
        err_next = 1'b1;
      end
    end else if (psel && penable && !rdy_reg) begin
      err_next = err_reg;
    end
    if (wr_acc) begin
      if (paddr == ADDR_CTRL) begin
        ctrl_next = pwdata[15:0];
      end else if (paddr == ADDR_BUFCNT) begin
        cap_next = pwdata[BUF_W-1:0];
      end else if (paddr == ADDR_EVENT) begin
        evt_next = evt_reg & ~pwdata[2:0];
      end else if (paddr == ADDR_MASK) begin
        mask_next = pwdata[2:0];
      end
    end
    // Set wins over a same-cycle clear
    if (gen_now && !st_reg.gen_fault) begin
      evt_next[0] = 1'b1;
    end
    if (static_exp && !st_reg.static_fault) begin
      evt_next[1] = 1'b1;
    end
    if (telegram_sent && st_reg.restart) begin
      evt_next[2] = 1'b1;
    end
    irq_next = |(evt_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      cap_reg <= '0;
      mask_reg <= MASK_RESET;
      evt_reg <= 3'h0;
      rdata_reg <= 32'h0;
      err_reg <= 1'b0;
      rdy_reg <= 1'b0;
      irq_reg <= 1'b0;
      st_reg <= '{gen_fault: 1'b0, heat_crit: 1'b0, heat_on: 1'b0, static_fault: 1'b0,
                  fill: 4'h0, restart: 1'b1}; // RL9
    end else begin
      ctrl_reg <= ctrl_next;
      cap_reg <= cap_next;
      mask_reg <= mask_next;
      evt_reg <= evt_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
      rdy_reg <= rdy_next;
      irq_reg <= irq_next;
      st_reg <= st_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = rdy_reg;
  // Error flag only stands in the answer cycle, so it is the output itself
  assign pslverr = err_reg;
  assign irq = irq_reg;
endmodule

// file: shared/sesw_pkg.sv
// Purpose: Constants and types for the extended status word block
// Assumes: 25 MHz pclk, APB with 32-bit data
// Notes: Offsets are byte addresses
package sesw_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned NOVAL_TIME_S = 10;
  localparam int unsigned STATIC_TIME_S = 60;
  localparam int unsigned CYC_PER_S = CLK_HZ;
  localparam int unsigned AVG_LONG_S = 10;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_BUFCNT = 8'h08;
  localparam logic [7:0] ADDR_EVENT = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_TELEGRAM = 8'h14;
  localparam int BIT_GEN = 0;
  localparam int BIT_HCRIT = 1;
  localparam int BIT_HON = 2;
  localparam int BIT_STATIC = 4;
  localparam int FILL_LSB = 8;
  localparam int BIT_RESTART = 13;
  localparam logic [15:0] CTRL_RESET = 16'h0001;
  localparam logic [2:0] MASK_RESET = 3'h0;
  typedef struct packed {
    logic gen_fault;
    logic heat_crit;
    logic heat_on;
    logic static_fault;
    logic [3:0] fill;
    logic restart;
  } sesw_stat_s;
endpackage

// file: src/sesw_sec_timer.sv
// Purpose: Counts seconds since last event, flags when limit reached, or when passed if STRICT
// Assumes: Single pclk domain
// Notes: Limit is in seconds; tick pulse each second
`timescale 1ns/10ps
module sesw_sec_timer
  import sesw_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = CYC_PER_S,
  parameter int unsigned LIMIT_S = NOVAL_TIME_S,
  parameter bit STRICT = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  output logic expired
);
  logic [31:0] cyc_reg, cyc_next;
  logic [15:0] sec_reg, sec_next;
  logic exp_reg, exp_next;
  always_comb begin
    cyc_next = cyc_reg + 32'h1;
    sec_next = sec_reg;
    if (cyc_reg == CYC_PER_SEC - 1) begin
      cyc_next = 32'h0;
      if (sec_reg != 16'hffff) begin
        sec_next = sec_reg + 16'h1;
      end
    end
    if (clear) begin
      cyc_next = 32'h0;
      sec_next = 16'h0;
    end
    // Strict: more than limit, else at or above limit
    exp_next = STRICT ? (sec_reg > 16'(LIMIT_S)) : (sec_reg >= 16'(LIMIT_S));
    if (clear) begin
      exp_next = 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_reg <= 32'h0;
      sec_reg <= 16'h0;
      exp_reg <= 1'b0;
    end else begin
      cyc_reg <= cyc_next;
      sec_reg <= sec_next;
      exp_reg <= exp_next;
    end
  end
  assign expired = exp_reg;
endmodule

// file: verif/sesw_props.sv
// Purpose: Port checks of the status block
// Assumes: Status fields lag inputs by a cycle
// Notes: Bound from tb
`timescale 1ns/10ps
module sesw_props
  import sesw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic heat_crit,
  input wire logic heat_on,
  input wire logic static_cond,
  input wire logic telegram_sent
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_stat;
    pready && !pwrite && paddr == ADDR_STATUS;
  endsequence
  resp_one_a: assert property (psel && !penable |=> pready) else $error("no answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  unmapped_err_a: assert property (pready && paddr > 8'h14 |-> pslverr) else $error("no error");
  rsvd_zero_a: assert property (rd_stat |-> (prdata & 32'hffffd0e8) == 32'h0)
    else $error("reserved bit set");
  heat_crit_a: assert property (heat_crit [*4] ##1 rd_stat |-> prdata[BIT_HCRIT])
    else $error("criterion bit low");
  heat_off_a: assert property (!heat_on [*4] ##1 rd_stat |-> !prdata[BIT_HON])
    else $error("heating bit high");
  static_off_a: assert property (!static_cond [*4] ##1 rd_stat |-> !prdata[BIT_STATIC])
    else $error("static bit high");
  restart_clr_a: assert property (telegram_sent ##[3:200] rd_stat |-> !prdata[BIT_RESTART])
    else $error("restart flag kept");
endmodule

// file: verif/sesw_host.sv
// Purpose: Telegram receiver model
// Assumes: One telegram per send pulse
// Notes: Emits the telegram strobe a cycle later
`timescale 1ns/10ps
module sesw_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic send,
  output logic telegram_sent
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      telegram_sent <= 1'b0;
    end else begin
      telegram_sent <= send;
    end
  end
endmodule

// file: verif/tb.sv
// Purpose: Self-checking bench of the status block
// Assumes: Two cycles stand for one second
// Notes: Reads queue a note, a monitor compares
`timescale 1ns/10ps
module tb
  import sesw_pkg::*;
;
  localparam int unsigned CPS = 2;
  logic pclk, presetn, psel, penable, pwrite, new_value, heat_crit, heat_on, static_cond, send;
  logic pready, pslverr, irq, telegram_sent;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, lfsr;
  logic [15:0] buf_count;
  logic [33:0] exp_q[$];
  logic [33:0] note;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  sesw_status #(.CYC_PER_SEC(CPS)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .new_value(new_value), .buf_count(buf_count),
    .heat_crit(heat_crit), .heat_on(heat_on), .static_cond(static_cond),
    .telegram_sent(telegram_sent), .irq(irq));
  sesw_host i_host (.pclk(pclk), .presetn(presetn), .send(send), .telegram_sent(telegram_sent));
  task automatic stop_test();
    $display("Errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {2'b10, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 34'h0);
  endtask
  function automatic logic [31:0] st(input logic g, input logic s, input logic r,
                                     input logic [3:0] f);
    return {18'h0, r, 1'b0, f, 3'h0, s, 1'b0, heat_on, heat_crit, g};
  endfunction
  function automatic logic [3:0] fl(input int c, input int cap);
    if (c == 0 || cap == 0) return 4'h0;
    return 4'((16 * c + cap - 1) / cap - 1);
  endfunction
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  always @(posedge pclk) begin
    cycles++;
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) chk(prdata, note[31:0]);
    end
    if (cycles > 3000) begin
      n_errors++;
      $display("Error at %0t: timeout", $time);
      stop_test();
    end
  end
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    {psel, penable, pwrite, heat_crit, heat_on, static_cond, send, presetn} = '0;
    new_value = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    buf_count = 16'h0;
    lfsr = 32'hb95f;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_STATUS, 32'h2000);
    rd(ADDR_CTRL, {16'h0, CTRL_RESET});
    apb(1'b0, 8'h20, 32'h0, 34'h100000000);
    for (int i = 0; i < 4; i++) begin
      heat_crit <= i[0];
      heat_on <= i[1];
      repeat (3) @(posedge pclk);
      rd(ADDR_STATUS, st(0, 0, 1, 0));
    end
    wr(ADDR_BUFCNT, 32'd32);
    for (int i = 0; i < 6; i++) begin
      lfsr = nx(lfsr);
      buf_count <= (i == 0) ? 16'd32 : (i == 1) ? 16'd1 : 16'(lfsr % 33);
      repeat (3) @(posedge pclk);
      rd(ADDR_STATUS, st(0, 0, 1, fl(buf_count, 32)));
    end
    wr(ADDR_CTRL, 32'd20);
    for (int i = 9; i < 11; i++) begin
      buf_count <= 16'(i);
      repeat (4) @(posedge pclk);
      rd(ADDR_STATUS, st(i == 9, 0, 1, fl(i, 32)));
    end
    // Clear stale events first, else irq would hide the timer edge
    wr(ADDR_CTRL, 32'd5);
    wr(ADDR_EVENT, 32'h7);
    wr(ADDR_MASK, 32'h1);
    new_value <= 1'b0;
    repeat (5 * CPS) @(posedge pclk);
    rd(ADDR_STATUS, st(0, 0, 1, fl(10, 32)));
    repeat (8 * CPS) @(posedge pclk);
    rd(ADDR_STATUS, st(1, 0, 1, fl(10, 32)));
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_EVENT, 32'h1);
    new_value <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    static_cond <= 1'b1;
    repeat (55 * CPS) @(posedge pclk);
    rd(ADDR_STATUS, st(0, 0, 1, fl(10, 32)));
    repeat (10 * CPS) @(posedge pclk);
    rd(ADDR_STATUS, st(0, 1, 1, fl(10, 32)));
    static_cond <= 1'b0;
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(ADDR_STATUS, st(0, 0, 0, fl(10, 32)));
    // Second restart must raise the flag again
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_STATUS, st(0, 0, 1, 4'h0));
    repeat (2) @(posedge pclk);
    stop_test();
  end
endmodule
bind sesw_status sesw_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .heat_crit(heat_crit), .heat_on(heat_on), .static_cond(static_cond),
  .telegram_sent(telegram_sent));
